// file: src/xbp_pkg.sv
// shared constants and types for the external bus programmed i/o link
// Behaviour
// - peripheral decodes instruction bits 03..08
// - pulses need pause, external, instruction bit
// - bit09 pulse4, bit10 pulse2, bit11 pulse1
// - peripheral regenerates pulses as local operations
// - peripheral may combine pulses freely
// - ready flag drives skip on test
// - two-stage skip counter clocked near pulse end
// - one skip: ctl two, data bit 11
// - two skips: three strobes, data bit 10
// - processor halted until final strobe restarts
// - minimum halt 2.6, 3.6, 4.6 us
// - pulse 800ns min, gap 200ns min
// - no fixed slots, next pulse immediately
// - input data asserts ctl one, inverted
// - jam load needs grounded accumulator clear
// - ready flag grounds interrupt request
// - interrupting peripherals support skip test
// - at most three skips per instruction
// - 600ns init pulse clears flags
package xbp_pkg;
  localparam int CLK_MHZ        = 20;
  localparam int PULSE_MIN_NS   = 800;
  localparam int GAP_MIN_NS     = 200;
  localparam int STROBE_NS      = 100;
  localparam int INIT_NS        = 600;
  localparam int LEAD_NS        = 1800; // lead-in so one pulse halts at least 2.6 us
  localparam int SCALE_MAX      = 5;
  // least times round up to whole cycles
  localparam int PULSE_CYC  = (PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int GAP_CYC    = (GAP_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int INIT_CYC   = (INIT_NS * CLK_MHZ + 999) / 1000;
  localparam int LEAD_CYC   = (LEAD_NS * CLK_MHZ + 999) / 1000;
  // instruction field positions
  localparam int SEL_LSB = 3;
  localparam int SEL_MSB = 8;
  localparam int BIT_P4  = 9;
  localparam int BIT_P2  = 10;
  localparam int BIT_P1  = 11;
  localparam int WORD_W  = 12;
  // data bit driven for one and two skips (bit 11 is lsb in this numbering)
  localparam int SKIP1_BIT = 11;
  localparam int SKIP2_BIT = 10;
  localparam logic [5:0] DEV_CODE_DEF = 6'h2A; // arbitrary device code
  typedef enum logic [2:0] {
    XBP_IDLE  = 3'b000,
    XBP_PULSE = 3'b001,
    XBP_GAP   = 3'b010,
    XBP_APPLY = 3'b011,
    XBP_DONE  = 3'b100,
    XBP_LEAD  = 3'b101
  } xbp_state_t;
  // map documented bit index (0 = msb) to vector index
  function automatic int bitpos(input int n);
    return WORD_W - 1 - n;
  endfunction
endpackage

// file: src/xbp_if.sv
// external bus between adapter and peripheral
`timescale 1ns/1ps
interface xbp_if;
  logic [11:0] buffered_instr_bits;
  logic [2:0]  io_strobe_pulse;   // [0]=pulse1 [1]=pulse2 [2]=pulse4
  logic        skip_n_o;          // peripheral drives low
  logic        skip_n_oe;
  logic        irq_n_o;
  logic        irq_n_oe;
  logic [11:0] accum_in_n_o;
  logic [11:0] accum_in_n_oe;
  logic        accum_clear_n_o;
  logic        accum_clear_n_oe;
  logic        init_pulse;
  // wired-or resolution: any enabled low driver pulls the line low
  logic        skip_n;
  logic        irq_n;
  logic [11:0] accum_in_n;
  logic        accum_clear_line_n;
  assign skip_n             = ~(skip_n_oe & ~skip_n_o);
  assign irq_n              = ~(irq_n_oe & ~irq_n_o);
  assign accum_in_n         = ~(accum_in_n_oe & ~accum_in_n_o);
  assign accum_clear_line_n = ~(accum_clear_n_oe & ~accum_clear_n_o);
  modport adapter (output buffered_instr_bits, io_strobe_pulse, init_pulse,
                   input skip_n, irq_n, accum_in_n, accum_clear_line_n);
  modport periph (input buffered_instr_bits, io_strobe_pulse, init_pulse,
                  output skip_n_o, skip_n_oe, irq_n_o, irq_n_oe, accum_in_n_o,
                  accum_in_n_oe, accum_clear_n_o, accum_clear_n_oe);
endinterface

// file: src/xbp_pulse_timer.sv
// programmable width counter used for pulse, gap and init timing
`timescale 1ns/1ps
module xbp_pulse_timer #(
  parameter int MIN_CYC = 4
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_b_i,
  input  wire logic       start_i,
  input  wire logic [2:0] scale_i,
  output logic            busy_o,
  output logic            last_o
);
  localparam int CW = $clog2(MIN_CYC * 5 + 1) + 1;
  logic [CW-1:0] count;
  logic [2:0]    sc;
  // scale of zero is treated as one so the minimum always holds
  assign sc = (scale_i == 3'h0) ? 3'h1 : ((scale_i > 3'h5) ? 3'h5 : scale_i);
  // load length on start, count down to zero
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count <= '0;
    end else if (start_i) begin
      count <= CW'(MIN_CYC * sc);
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end
  assign busy_o = (count != '0);
  assign last_o = (count == CW'(1));
endmodule // xbp_pulse_timer

// file: src/xbp_adapter.sv
// bus adapter end: pulse generator, skip counter, input data path
`timescale 1ns/1ps
module xbp_adapter (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  xbp_if.adapter           bus,
  input  wire logic        io_pause_i,
  input  wire logic        internal_io_i,
  input  wire logic [11:0] memory_data_line_i,
  input  wire logic [2:0]  width_scale_i,
  input  wire logic [2:0]  gap_scale_i,
  input  wire logic        init_req_i,
  output logic             halt_o,
  output logic             bus_strobe_o,
  output logic             int_strobe_o,
  output logic             ctl_line_zero_o,
  output logic             ctl_line_one_o,
  output logic             ctl_line_two_o,
  output logic [11:0]      data_o,
  output logic             irq_o
);
  xbp_pkg::xbp_state_t state;
  logic [2:0]  pending;
  logic [2:0]  active;
  logic [1:0]  skip_cnt;
  logic [11:0] instr;
  logic        p_start;
  logic        p_last;
  logic        g_start;
  logic        g_last;
  logic        l_start;
  logic        l_last;
  logic        i_start;
  logic        i_busy;
  logic        pause_q;
  logic        skip_q1, skip_q2, irq_q1, irq_q2, clr_q1, clr_q2;
  logic [11:0] acc_q1, acc_q2;

  // bus pins pass two flops before use
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {skip_q1, skip_q2, irq_q1, irq_q2, clr_q1, clr_q2} <= 6'h3F;
      acc_q1 <= 12'hFFF;
      acc_q2 <= 12'hFFF;
    end else begin
      skip_q1 <= bus.skip_n;
      skip_q2 <= skip_q1;
      irq_q1  <= bus.irq_n;
      irq_q2  <= irq_q1;
      clr_q1  <= bus.accum_clear_line_n;
      clr_q2  <= clr_q1;
      acc_q1  <= bus.accum_in_n;
      acc_q2  <= acc_q1;
    end
  end

  assign irq_o = ~irq_q2;

  // width and gap timers apart, so each keeps its own minimum and scale
  xbp_pulse_timer #(.MIN_CYC(xbp_pkg::PULSE_CYC)) u_timer (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .start_i   (p_start),
    .scale_i   (width_scale_i),
    .busy_o    (),
    .last_o    (p_last)
  );
  xbp_pulse_timer #(.MIN_CYC(xbp_pkg::GAP_CYC)) u_gap (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .start_i   (g_start),
    .scale_i   (gap_scale_i),
    .busy_o    (),
    .last_o    (g_last)
  );

  // fixed lead-in before the first pulse holds the minimum halt
  xbp_pulse_timer #(.MIN_CYC(xbp_pkg::LEAD_CYC)) u_lead (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .start_i   (l_start),
    .scale_i   (3'h1),
    .busy_o    (),
    .last_o    (l_last)
  );

  xbp_pulse_timer #(.MIN_CYC(xbp_pkg::INIT_CYC)) u_init (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .start_i   (i_start),
    .scale_i   (3'h1),
    .busy_o    (i_busy),
    .last_o    ()
  );
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      i_start <= 1'b1; // power-up init
    end else begin
      i_start <= init_req_i & ~i_busy;
    end
  end
  assign bus.init_pulse = i_busy;

  // lowest pending weight goes next: pulse1, then 2, then 4
  function automatic logic [2:0] lowest(input logic [2:0] p);
    if (p[0]) return 3'b001;
    if (p[1]) return 3'b010;
    if (p[2]) return 3'b100;
    return 3'b000;
  endfunction

  // sequencer timer launches; a timer's last cycle only counts in its own phase
  always_comb begin
    l_start = 1'b0;
    p_start = 1'b0;
    g_start = 1'b0;
    unique case (state)
      xbp_pkg::XBP_IDLE:  l_start = pause_q;
      xbp_pkg::XBP_LEAD:  p_start = l_last;
      xbp_pkg::XBP_PULSE: g_start = p_last && (pending != 3'b000);
      xbp_pkg::XBP_GAP:   p_start = g_last;
      xbp_pkg::XBP_APPLY: l_start = 1'b0;
      xbp_pkg::XBP_DONE:  l_start = 1'b0;
      default:            l_start = 1'b0;
    endcase
  end

  // accept only external pause with bits set
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pause_q <= 1'b0;
    end else begin
      pause_q <= (state == xbp_pkg::XBP_IDLE) && !pause_q && io_pause_i && !internal_io_i
                 && (memory_data_line_i[2:0] != 3'b000);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state   <= xbp_pkg::XBP_IDLE;
      pending <= 3'b000;
      active  <= 3'b000;
      instr   <= 12'h000;
    end else begin
      unique case (state)
        xbp_pkg::XBP_IDLE: if (pause_q) begin
          // bit09 p4, bit10 p2, bit11 p1
          instr   <= memory_data_line_i;
          active  <= lowest(memory_data_line_i[2:0]);
          pending <= memory_data_line_i[2:0] & ~lowest(memory_data_line_i[2:0]);
          state   <= xbp_pkg::XBP_LEAD;
        end
        xbp_pkg::XBP_LEAD: if (l_last) begin
          state <= xbp_pkg::XBP_PULSE;
        end
        xbp_pkg::XBP_PULSE: if (p_last) begin
          active <= 3'b000;
          state  <= (pending != 3'b000) ? xbp_pkg::XBP_GAP : xbp_pkg::XBP_APPLY;
        end
        xbp_pkg::XBP_GAP: if (g_last) begin
          active  <= lowest(pending);
          pending <= pending & ~lowest(pending);
          state   <= xbp_pkg::XBP_PULSE;
        end
        xbp_pkg::XBP_APPLY: state <= xbp_pkg::XBP_DONE;
        xbp_pkg::XBP_DONE:  if (!io_pause_i) state <= xbp_pkg::XBP_IDLE;
        default: state <= xbp_pkg::XBP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus.io_strobe_pulse <= 3'b000;
      bus.buffered_instr_bits <= 12'h000;
    end else begin
      bus.io_strobe_pulse <= (state == xbp_pkg::XBP_PULSE) ? active : 3'b000;
      bus.buffered_instr_bits <= (state == xbp_pkg::XBP_IDLE) ? memory_data_line_i : instr;
    end
  end

  // skip counter strobed near pulse end; saturates at three
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      skip_cnt <= 2'b00;
    end else if (state == xbp_pkg::XBP_IDLE) begin
      skip_cnt <= 2'b00;
    end else if (state == xbp_pkg::XBP_PULSE && p_last && !skip_q2 && skip_cnt != 2'b11) begin
      skip_cnt <= skip_cnt + 2'b01;
    end
  end

  // skip add and input transfer at apply
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctl_line_zero_o <= 1'b0;
      ctl_line_one_o  <= 1'b0;
      ctl_line_two_o  <= 1'b0;
      data_o          <= 12'h000;
    end else if (state == xbp_pkg::XBP_APPLY) begin
      if (skip_cnt != 2'b00) begin
        ctl_line_two_o <= 1'b1;
        ctl_line_one_o <= 1'b0;
        ctl_line_zero_o <= 1'b0;
        data_o <= 12'(skip_cnt); // lsb is bit 11, next is bit 10
      end else begin
        // inverted data: ground on a line is a one
        ctl_line_one_o  <= (acc_q2 != 12'hFFF) || !clr_q2;
        ctl_line_zero_o <= !clr_q2;
        ctl_line_two_o  <= 1'b0;
        data_o          <= ~acc_q2;
      end
    end else if (state == xbp_pkg::XBP_IDLE) begin
      {ctl_line_zero_o, ctl_line_one_o, ctl_line_two_o} <= 3'b000;
      data_o <= 12'h000;
    end
  end

  // halt from pause until final strobe
  assign halt_o       = (state != xbp_pkg::XBP_IDLE) && (state != xbp_pkg::XBP_DONE);
  assign bus_strobe_o = (state == xbp_pkg::XBP_PULSE && p_last) || (state == xbp_pkg::XBP_APPLY);
  assign int_strobe_o = (state == xbp_pkg::XBP_APPLY);
endmodule // xbp_adapter

// file: src/xbp_periph.sv
// peripheral end: device selector, local operations, ready flag
`timescale 1ns/1ps
module xbp_periph #(
  parameter logic [5:0] DEV_CODE = xbp_pkg::DEV_CODE_DEF
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  xbp_if.periph            bus,
  input  wire logic        ready_set_i,
  input  wire logic [11:0] send_data_i,
  input  wire logic        int_enable_i,
  output logic [2:0]       local_op_o,
  output logic             ready_flag_o
);
  logic [2:0] op_q;
  logic       match;
  assign match = (bus.buffered_instr_bits[8:3] == DEV_CODE);
  // local ops, pulses combine over instruction
  assign local_op_o = match ? bus.io_strobe_pulse : 3'b000;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      op_q <= 3'b000;
    end else begin
      op_q <= local_op_o;
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ready_flag_o <= 1'b0;
    end else if (ready_set_i) begin
      ready_flag_o <= 1'b1;
    end else if (bus.init_pulse || (op_q[1] && !local_op_o[1])) begin
      ready_flag_o <= 1'b0;
    end
  end
  assign bus.skip_n_o  = 1'b0;
  assign bus.skip_n_oe = local_op_o[0] & ready_flag_o;
  assign bus.irq_n_o  = 1'b0;
  assign bus.irq_n_oe = ready_flag_o & int_enable_i;
  // data on op4; clear only during op4
  assign bus.accum_in_n_o  = 12'h000;
  assign bus.accum_in_n_oe = local_op_o[2] ? send_data_i : 12'h000;
  // op 6: pulse 2 and 4 in one instruction make a jam
  // decoded from the held bits, so nothing leaks into the next instruction
  assign bus.accum_clear_n_o  = 1'b0;
  assign bus.accum_clear_n_oe = local_op_o[2] & bus.buffered_instr_bits[1];
endmodule // xbp_periph

// file: test/xbp_link_asserts.sv
// checker for the bus between adapter and peripheral
`timescale 1ns/1ps
module xbp_link_asserts (
  input wire logic        clk_sys_i,
  input wire logic        rst_b_i,
  input wire logic [11:0] buffered_instr_bits,
  input wire logic [2:0]  io_strobe_pulse,
  input wire logic        skip_n,
  input wire logic [11:0] accum_in_n,
  input wire logic        accum_clear_line_n,
  input wire logic        init_pulse
);
  logic [7:0] pw_cnt;
  logic [4:0] in_cnt;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  // run lengths; counters, not $fell, so a reset never ends a pulse
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pw_cnt <= 8'h00;
      in_cnt <= 5'h00;
    end else begin
      pw_cnt <= (|io_strobe_pulse) ? pw_cnt + 8'h01 : 8'h00;
      in_cnt <= init_pulse ? in_cnt + 5'h01 : 5'h00;
    end
  end
  sequence s_pulse_end;
    pw_cnt != 8'h00 && io_strobe_pulse == 3'h0;
  endsequence
  sequence s_quiet;
    (io_strobe_pulse == 3'h0)[*4];
  endsequence
  property p_width;
    s_pulse_end |-> pw_cnt >= 8'h10 && pw_cnt <= 8'h50;
  endproperty
  a_width: assert property (p_width) else $error("pulse width");
  property p_gap;
    s_pulse_end |-> s_quiet;
  endproperty
  a_gap: assert property (p_gap) else $error("pulse gap");
  property p_map;
    (io_strobe_pulse & ~buffered_instr_bits[2:0]) == 3'h0;
  endproperty
  a_map: assert property (p_map) else $error("pulse without bit");
  property p_steady;
    |io_strobe_pulse |-> $stable(buffered_instr_bits);
  endproperty
  a_steady: assert property (p_steady) else $error("bits moved");
  property p_init;
    in_cnt != 5'h00 && !init_pulse |-> in_cnt == 5'h0C;
  endproperty
  a_init: assert property (p_init) else $error("init width");
  property p_skip;
    !skip_n |-> io_strobe_pulse[0];
  endproperty
  a_skip: assert property (p_skip) else $error("skip off test");
  property p_clear;
    !accum_clear_line_n |-> buffered_instr_bits[2] && buffered_instr_bits[1];
  endproperty
  a_clear: assert property (p_clear) else $error("stray clear");
  property p_data;
    accum_in_n != 12'hFFF |-> buffered_instr_bits[2];
  endproperty
  a_data: assert property (p_data) else $error("stray data");
endmodule // xbp_link_asserts

// file: test/external_bus_programmed_io_test.sv
// bench joining adapter and peripheral over the external bus
`timescale 1ns/1ps
module external_bus_programmed_io_test;
  localparam logic [5:0] DEV = xbp_pkg::DEV_CODE_DEF;
  localparam int         WATCH_CYC = 20000; // several times the expected run
  logic        clk_sys_i = 1'b0, rst_b_i = 1'b0, io_pause_i = 1'b0, internal_io_i = 1'b0;
  logic        init_req_i = 1'b0, ready_set_i = 1'b0, int_enable_i = 1'b0, got_int;
  logic [11:0] memory_data_line_i = 12'h000, send_data_i = 12'h000, data_o, c_dat;
  logic [2:0]  width_scale_i = 3'h1, gap_scale_i = 3'h1, local_op_o, seen_p, seen_op, c_ctl;
  logic        halt_o, bus_strobe_o, int_strobe_o, irq_o, ready_flag_o;
  logic        ctl_line_zero_o, ctl_line_one_o, ctl_line_two_o;
  int          n_mismatch = 0, comparisons = 0, halt_cyc, strobe_cnt;
  xbp_if i_xbp_if();
  always #25 clk_sys_i = ~clk_sys_i;
  xbp_adapter i_xbp_adapter (.clk_sys_i, .rst_b_i, .bus(i_xbp_if), .io_pause_i, .internal_io_i,
    .memory_data_line_i, .width_scale_i, .gap_scale_i, .init_req_i, .halt_o, .bus_strobe_o,
    .int_strobe_o, .ctl_line_zero_o, .ctl_line_one_o, .ctl_line_two_o, .data_o, .irq_o);
  xbp_periph i_xbp_periph (.clk_sys_i, .rst_b_i, .bus(i_xbp_if), .ready_set_i, .send_data_i,
    .int_enable_i, .local_op_o, .ready_flag_o);
  xbp_link_asserts i_xbp_link_asserts (.clk_sys_i, .rst_b_i,
    .buffered_instr_bits(i_xbp_if.buffered_instr_bits), .skip_n(i_xbp_if.skip_n),
    .io_strobe_pulse(i_xbp_if.io_strobe_pulse), .accum_in_n(i_xbp_if.accum_in_n),
    .accum_clear_line_n(i_xbp_if.accum_clear_line_n), .init_pulse(i_xbp_if.init_pulse));
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // waits n edges, then lets their updates settle
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic set_ready();
    @(posedge clk_sys_i);
    ready_set_i <= 1'b1;
    @(posedge clk_sys_i);
    ready_set_i <= 1'b0;
    tick(3);
  endtask
  // one instruction; control lines are captured before the pause ends
  task automatic run(input logic [5:0] dev, input logic [2:0] ops, input logic intern);
    halt_cyc = 0;
    strobe_cnt = 0;
    seen_p = 3'h0;
    seen_op = 3'h0;
    got_int = 1'b0;
    @(posedge clk_sys_i);
    memory_data_line_i <= {3'h6, dev, ops};
    internal_io_i <= intern;
    io_pause_i <= 1'b1;
    for (int i = 0; i < 400 && !got_int; i++) begin
      tick(1);
      halt_cyc += int'(halt_o === 1'b1);
      strobe_cnt += int'(bus_strobe_o === 1'b1);
      seen_p |= i_xbp_if.io_strobe_pulse;
      seen_op |= local_op_o;
      got_int = (int_strobe_o === 1'b1);
    end
    tick(1);
    c_ctl = {ctl_line_zero_o, ctl_line_one_o, ctl_line_two_o};
    c_dat = data_o;
    @(posedge clk_sys_i);
    io_pause_i <= 1'b0;
    tick(3);
  endtask
  task automatic t_init();
    int w = 0;
    for (int i = 0; i < 60; i++) begin
      tick(1);
      w += int'(i_xbp_if.init_pulse === 1'b1);
    end
    check("init_width", 12'h00C, 12'(w));
    set_ready();
    check("flag_set", 12'h001, {11'h0, ready_flag_o});
    @(posedge clk_sys_i);
    init_req_i <= 1'b1;
    @(posedge clk_sys_i);
    init_req_i <= 1'b0;
    tick(30);
    check("flag_init", 12'h000, {11'h0, ready_flag_o});
    $display("test init done");
  endtask
  // every pulse mix, then a foreign code and an internal transfer
  task automatic t_ops();
    int n;
    for (int k = 1; k < 8; k++) begin
      n = int'(k[0]) + int'(k[1]) + int'(k[2]);
      run(DEV, 3'(k), 1'b0);
      check("pulses", 12'(k), {9'h0, seen_p});
      check("local_ops", 12'(k), {9'h0, seen_op});
      check("halt_min", 12'h001, 12'(halt_cyc >= 32 + 20 * n));
      check("no_skip", 12'h000, {11'h0, c_ctl[0]});
      if (n < 3) check("strobes", 12'(n + 1), 12'(strobe_cnt));
    end
    run(DEV ^ 6'h01, 3'h7, 1'b0);
    check("foreign", 12'h000, {9'h0, seen_op});
    run(DEV, 3'h7, 1'b1);
    check("internal", 12'h000, {9'h0, seen_p});
    $display("test ops done");
  endtask
  // skip on a set flag, the flag clearing, and its interrupt request
  task automatic t_skip();
    set_ready();
    @(posedge clk_sys_i);
    int_enable_i <= 1'b1;
    tick(3);
    check("irq", 12'h001, {11'h0, irq_o});
    check("irq_line", 12'h000, {11'h0, i_xbp_if.irq_n});
    run(DEV, 3'h1, 1'b0);
    check("skip_ctl", 12'h001, {9'h0, c_ctl});
    check("skip_data", 12'h001, c_dat);
    run(DEV, 3'h3, 1'b0);
    check("skip_once", 12'h001, c_dat);
    check("flag_clr", 12'h000, {11'h0, ready_flag_o});
    check("irq_off", 12'h000, {11'h0, irq_o});
    run(DEV, 3'h1, 1'b0);
    check("skip_none", 12'h000, {9'h0, c_ctl});
    $display("test skip done");
  endtask
  task automatic t_data();
    @(posedge clk_sys_i);
    send_data_i <= 12'hA5C;
    run(DEV, 3'h4, 1'b0);
    check("ctl_or", 12'h002, {9'h0, c_ctl});
    check("data_in", 12'hA5C, c_dat);
    run(DEV, 3'h6, 1'b0);
    check("ctl_jam", 12'h006, {9'h0, c_ctl});
    $display("test data done");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    t_init();
    t_ops();
    t_skip();
    t_data();
    tally_and_finish();
  end
  // a hang is cut short and counted
  initial begin
    repeat (WATCH_CYC) @(posedge clk_sys_i);
    n_mismatch++;
    tally_and_finish();
  end
endmodule // external_bus_programmed_io_test
